// *** design/sra_spi_slave.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// - Each transaction is a 40-bit frame, one bit returned per bit received.
// - A frame holds an address byte then four data bytes, full 32-bit words.
// - Frame bit 39 picks direction, one writes, zero reads; seven address bits follow.
// - Read frames carry dummy data that never reaches the addressed register.
// - Every frame returns a 32-bit data word, read or write.
// - After a read frame, the next frame returns that address's register content.
// - After a write frame, the next frame returns that frame's write data.
// - Read data is captured right after the read completes, allowing pipelined reads.
// - Words are right aligned; signed values two's complement, unsigned plain binary.
// - A transaction starts only on a falling edge of select.
// - Input sampled on rising serial clock, output updated after falling edge.
// - Both directions send the most significant bit first.
// - The first eight returned bits are the status byte, then the data word.
// - Frames shorter than 40 clocks are invalid; eight clocks just fetch status.
// - Clocks beyond 40 pass input bits to the output delayed by 40 clocks.
// - On select rising, the last 40 bits in execute as read or write.
// - Serial clock stays at or below a quarter of the system clock.
// - The serial output is released whenever select is high.
// - With over eight events selected, the lowest-index eight are reported.
module sra_spi_slave #(
  parameter int EVENT_W = sra_pkg::EVENT_W_DEF
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic host_select_n_i,
  input wire logic host_serial_clock_i,
  input wire logic host_serial_in_i,
  output logic host_serial_out_o,
  output logic host_serial_out_oe_o,
  input wire logic [EVENT_W-1:0] event_i,
  input wire logic [EVENT_W-1:0] event_sel_i,
  input wire logic [sra_pkg::DATA_W-1:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [sra_pkg::ADDR_W-1:0] reg_addr_o,
  output logic [sra_pkg::DATA_W-1:0] reg_wdata_o
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (EVENT_W < sra_pkg::STAT_W || EVENT_W > 256) begin : g_bad_event_w
    $error("EVENT_W must lie between the status width and 256.");
  end

  // ----------------------------------------------------------------
  // Status selection
  // ----------------------------------------------------------------
  function automatic logic [sra_pkg::STAT_W-1:0] pick_status(
    input logic [EVENT_W-1:0] ev,
    input logic [EVENT_W-1:0] sel
  );
    logic [sra_pkg::STAT_W-1:0] res;
    int n;
    res = sra_pkg::STATUS_RST;
    n = 0;
    for (int i = 0; i < EVENT_W; i++) begin
      if (sel[i] && n < sra_pkg::STAT_W) begin
        res[n] = ev[i];
        n = n + 1;
      end
    end
    return res;
  endfunction

  logic sel_s1;
  logic sel_s2;
  logic sel_s3;
  logic [sra_pkg::STAT_W-1:0] status_hold;
  logic [sra_pkg::DATA_W-1:0] reply;
  logic [sra_pkg::FRAME_BITS-1:0] shift;
  logic [sra_pkg::CNT_W-1:0] bit_cnt;
  logic frame_open;
  logic out_live;
  logic sdo_q;

  wire [sra_pkg::STAT_W-1:0] next_status = pick_status(event_i, event_sel_i);
  wire [sra_pkg::FRAME_BITS-1:0] tx_word = {status_hold, reply};

  // ----------------------------------------------------------------
  // Link side, serial clock domain
  // ----------------------------------------------------------------
  wire start_rst = sys_rst_i | host_select_n_i;
  wire [sra_pkg::FRAME_BITS-1:0] next_shift = frame_open ?
    {tx_word[sra_pkg::FRAME_BITS-2:0], host_serial_in_i} :
    {shift[sra_pkg::FRAME_BITS-2:0], host_serial_in_i};
  wire [sra_pkg::CNT_W-1:0] next_bit_cnt = frame_open ? sra_pkg::CNT_FIRST :
    (bit_cnt == sra_pkg::CNT_MAX) ? bit_cnt : bit_cnt + sra_pkg::CNT_FIRST;

  always_ff @(posedge host_serial_clock_i or posedge start_rst) begin
    if (start_rst) begin
      frame_open <= 1'b1;
    end else begin
      frame_open <= 1'b0;
    end
  end

  always_ff @(posedge host_serial_clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift <= sra_pkg::SHIFT_RST;
      bit_cnt <= '0;
    end else begin
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
    end
  end

  always_ff @(negedge host_serial_clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= shift[sra_pkg::FRAME_BITS-1];
    end
  end

  always_ff @(negedge host_serial_clock_i or posedge start_rst) begin
    if (start_rst) begin
      out_live <= 1'b0;
    end else begin
      out_live <= 1'b1;
    end
  end

  // The first bit is shown from select low until the first falling edge.
  assign host_serial_out_o = out_live ? sdo_q : tx_word[sra_pkg::FRAME_BITS-1];
  assign host_serial_out_oe_o = ~host_select_n_i;

  // ----------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------
  // The shifter and counter are still while select is high, so they are read
  // here only after the synchronised select has risen.
  wire frame_end = sel_s2 & ~sel_s3;
  wire frame_valid = bit_cnt >= sra_pkg::FRAME_CNT;
  wire take_cmd = frame_end & frame_valid;
  wire cmd_write = shift[sra_pkg::RW_BIT];

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_s3 <= 1'b1;
    end else begin
      sel_s1 <= host_select_n_i;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
    end else begin
      reg_wr_o <= take_cmd & cmd_write;
      reg_rd_o <= take_cmd & ~cmd_write;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_addr_o <= '0;
      reg_wdata_o <= sra_pkg::REPLY_RST;
    end else if (take_cmd) begin
      reg_addr_o <= shift[sra_pkg::ADDR_MSB:sra_pkg::ADDR_LSB];
      reg_wdata_o <= shift[sra_pkg::DATA_W-1:0];
    end
  end

  // Register data is taken in the same cycle as the read strobe.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reply <= sra_pkg::REPLY_RST;
    end else if (reg_wr_o) begin
      reply <= reg_wdata_o;
    end else if (reg_rd_o) begin
      reply <= reg_rdata_i;
    end
  end

  // The status byte is frozen while a frame is under way.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_hold <= sra_pkg::STATUS_RST;
    end else if (sel_s2) begin
      status_hold <= next_status;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_valid_end;
    frame_end && frame_valid;
  endsequence

  sequence s_short_end;
    frame_end && !frame_valid;
  endsequence

  sequence s_write_end;
    frame_end && frame_valid && cmd_write;
  endsequence

  sequence s_read_end;
    frame_end && frame_valid && !cmd_write;
  endsequence

  sequence s_strobe;
    reg_wr_o || reg_rd_o;
  endsequence

  a_write_exec: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_write_end |=> reg_wr_o && !reg_rd_o && reg_wdata_o == $past(shift[31:0]))
    else $error("Valid write frame did not strobe a write.");

  a_read_exec: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_read_end |=> reg_rd_o && !reg_wr_o && reg_addr_o == $past(shift[38:32]))
    else $error("Valid read frame did not strobe a read alone.");

  a_short_ignored: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_short_end |=> !reg_wr_o && !reg_rd_o ##1 $stable(reply))
    else $error("Short frame caused a register access.");

  a_short_keeps: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_short_end |=> $stable(reg_addr_o) && $stable(reg_wdata_o))
    else $error("Short frame changed the pending command.");

  a_write_echo: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    reg_wr_o |=> reply == $past(reg_wdata_o))
    else $error("Write data not returned in the next frame.");

  a_read_latch: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    reg_rd_o |=> reply == $past(reg_rdata_i) ##1 $stable(reply))
    else $error("Read data not latched after the read.");

  a_strobe_single: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (reg_wr_o || reg_rd_o) |=> !reg_wr_o && !reg_rd_o)
    else $error("Register strobe lasted more than one cycle.");

  a_status_freeze: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    !sel_s2 && !$past(sel_s2) |-> $stable(status_hold))
    else $error("Status byte moved during a frame.");

  a_status_pick: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    sel_s2 |=> status_hold == $past(next_status))
    else $error("Status byte is not the lowest selected events.");

  a_frame_count: assert property (
    @(posedge host_serial_clock_i) disable iff (sys_rst_i)
    frame_open |=> bit_cnt == sra_pkg::CNT_FIRST && !frame_open)
    else $error("Frame did not restart its bit count.");

  a_pass_delay: assert property (
    @(posedge host_serial_clock_i) disable iff (sys_rst_i || host_select_n_i)
    !frame_open && bit_cnt >= sra_pkg::FRAME_CNT |-> shift[39] == $past(host_serial_in_i, 40))
    else $error("Pass-through bit is not delayed by 40 clocks.");

  a_valid_strobe: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_valid_end |=> s_strobe)
    else $error("Valid frame end gave no register strobe.");

  a_strobe_excl: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    !(reg_wr_o && reg_rd_o))
    else $error("Read and write strobes rose together.");

  a_strobe_cause: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_strobe |-> $past(take_cmd))
    else $error("Register strobe without a completed frame.");

  a_strobe_length: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_strobe |-> bit_cnt >= sra_pkg::FRAME_CNT)
    else $error("Register strobe after a short frame.");

  a_cmd_hold: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    !take_cmd |=> $stable(reg_addr_o) && $stable(reg_wdata_o))
    else $error("Command fields moved without a valid frame.");

  a_reply_hold: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    !reg_wr_o && !reg_rd_o |=> $stable(reply))
    else $error("Return word moved without a register strobe.");

  a_write_addr: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_write_end |=> reg_addr_o == $past(shift[sra_pkg::ADDR_MSB:sra_pkg::ADDR_LSB]))
    else $error("Write frame gave the wrong register address.");

  a_first_bit: assert property (
    @(posedge host_serial_clock_i) disable iff (sys_rst_i)
    frame_open |-> host_serial_out_o == status_hold[sra_pkg::STAT_W-1])
    else $error("First returned bit is not the top status bit.");

  a_tx_load: assert property (
    @(posedge host_serial_clock_i) disable iff (sys_rst_i || host_select_n_i)
    frame_open |=> shift[sra_pkg::FRAME_BITS-1] == $past(tx_word[sra_pkg::FRAME_BITS-2]))
    else $error("Return word was not loaded at frame start.");

  a_shift_in: assert property (
    @(posedge host_serial_clock_i) disable iff (sys_rst_i)
    !host_select_n_i |=> shift[0] == $past(host_serial_in_i))
    else $error("Serial input bit was not shifted in.");

  a_out_follow: assert property (
    @(posedge host_serial_clock_i) disable iff (sys_rst_i || host_select_n_i)
    !frame_open |-> host_serial_out_o == shift[sra_pkg::FRAME_BITS-1])
    else $error("Serial output did not follow the shift register.");

  a_count_step: assert property (
    @(posedge host_serial_clock_i) disable iff (sys_rst_i)
    !frame_open && bit_cnt != sra_pkg::CNT_MAX |=>
      bit_cnt == $past(bit_cnt) + sra_pkg::CNT_FIRST)
    else $error("Bit counter did not advance by one.");

endmodule

// *** include/sra_pkg.sv ***
package sra_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 40;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] FRAME_CNT = 6'h28;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
  localparam logic [CNT_W-1:0] CNT_FIRST = 6'h01;
  localparam int RW_BIT = 39;
  localparam int ADDR_MSB = 38;
  localparam int ADDR_LSB = 32;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam int STAT_W = 8;
  localparam int EVENT_W_DEF = 32;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] REPLY_RST = 32'h0000_0000;
  localparam logic [STAT_W-1:0] STATUS_RST = 8'h00;
  localparam logic [FRAME_BITS-1:0] SHIFT_RST = 40'h00_0000_0000;
  localparam int SCLK_RATIO_MIN = 4;

endpackage

// *** verif/sra_host_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host serial master
// ----------------------------------------------------------------
module sra_host_model (
  output logic sel_n_o,
  output logic sclk_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // Half period of the 8 MHz serial clock, far below a quarter of the system clock.
  localparam realtime HALF = 62.5;
  // Offset at each frame start keeps link edges clear of system clock edges.
  localparam realtime SKEW = 1.3;

  initial begin
    sel_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end

  // Runs one frame of n bits and returns what came back.
  task automatic xfer(input int n, input logic [47:0] din, output logic [47:0] dout);
    dout = '0;
    #(SKEW);
    mosi_o = din[n-1];
    sel_n_o = 1'b0;
    #(HALF);
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b1;
      dout[i] = miso_i;
      #(HALF);
      sclk_o = 1'b0;
      if (i > 0) begin
        mosi_o = din[i-1];
      end
      #(HALF);
    end
    sel_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #100;
  endtask

  // Sends one full command, with the write flag on top of the address byte.
  task automatic cmd(input logic wr, input logic [6:0] a, input logic [31:0] d,
                     output logic [39:0] r);
    logic [47:0] o;
    xfer(40, {8'h00, wr, a, d}, o);
    r = o[39:0];
  endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps

module testbench;
  logic mclk, sys_rst, sel_n, sclk, mosi, miso, oe, reg_wr, reg_rd;
  logic [31:0] ev, ev_sel, rdata, wdata;
  logic [6:0] addr;
  logic [31:0] regs [128];
  logic [7:0] st;
  int err_count, comparisons;
  int strobes = 0;

  sra_spi_slave uut (.mclk_i(mclk), .sys_rst_i(sys_rst), .host_select_n_i(sel_n),
    .host_serial_clock_i(sclk), .host_serial_in_i(mosi), .host_serial_out_o(miso),
    .host_serial_out_oe_o(oe), .event_i(ev), .event_sel_i(ev_sel), .reg_rdata_i(rdata),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(addr), .reg_wdata_o(wdata));
  sra_host_model host (.sel_n_o(sel_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso));

  // ----------------------------------------------------------------
  // Register file behind the port
  // ----------------------------------------------------------------
  assign rdata = regs[addr];
  always @(posedge mclk) begin
    if (reg_wr) begin
      regs[addr] <= wdata;
    end
  end

  always @(posedge mclk) begin
    if (reg_wr || reg_rd) begin
      strobes <= strobes + 1;
    end
  end

  always @(posedge sclk) begin
    chk(oe, 1'b1);
  end

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Expected status: the first eight selected events, lowest index in bit 0.
  task automatic status_exp;
    int j;
    st = 8'h00;
    j = 0;
    for (int i = 0; i < 32; i++) begin
      if (ev_sel[i] && j < 8) begin
        st[j] = ev[i];
        j++;
      end
    end
  endtask

  task automatic t_pipe;
    logic [39:0] r;
    host.cmd(1'b1, 7'h22, 32'h00ab_cdef, r);
    chk(r[39:32], st);
    host.cmd(1'b0, 7'h21, 32'hffff_ffff, r);
    chk(r[31:0], 32'h00ab_cdef);
    host.cmd(1'b0, 7'h00, 32'h0000_0000, r);
    chk(r[31:0], 32'h1000_0021);
    chk(regs[7'h22], 32'h00ab_cdef);
    chk(regs[7'h21], 32'h1000_0021);
    chk(strobes, 3);
    $display("test pipe done");
  endtask

  task automatic t_short;
    logic [39:0] r;
    logic [47:0] o;
    int n0;
    n0 = strobes;
    host.xfer(8, 48'h0000_0000_00a5, o);
    chk(o[7:0], st);
    chk(strobes, n0);
    host.cmd(1'b0, 7'h22, 32'h0000_0000, r);
    chk(r[31:0], 32'h1000_0000);
    chk(regs[7'h25], 32'h1000_0025);
    $display("test short done");
  endtask

  task automatic t_chain;
    logic [39:0] r;
    logic [47:0] o;
    host.xfer(48, {8'hc3, 8'h00, 32'h0000_0000}, o);
    chk(o[7:0], 8'hc3);
    chk(o[39:8], 32'h00ab_cdef);
    host.cmd(1'b0, 7'h00, 32'h0000_0000, r);
    chk(r[31:0], 32'h1000_0000);
    chk(regs[7'h43], 32'h1000_0043);
    chk(oe, 1'b0);
    $display("test chain done");
  endtask

  initial begin
    err_count = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    ev = 32'h5a3c_96e1;
    ev_sel = 32'h0f0f_0f0f;
    for (int i = 0; i < 128; i++) begin
      regs[i] = 32'h1000_0000 | i;
    end
    repeat (20) @(posedge mclk);
    @(negedge mclk) sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    status_exp();
    chk(oe, 1'b0);
    t_pipe();
    t_short();
    t_chain();
    wrap_up();
  end

  initial begin
    #300_000;
    err_count++;
    wrap_up();
  end
endmodule
